// [verilog/rr_exec_core.sv]
/*
 Execution core for returns and rotate-left operations. Holds the live
 working, status and bank-select registers and the two global interrupt
 enables, and sequences the four phases of every instruction cycle.
 Assumes: instruction word valid in phase Q1; data memory answers a read
 issued in Q2 with data in Q3; the return stack sits outside and shows its
 top on stack_top_in, dropping one level on each stack_pop_out pulse.
*/
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rr_exec_core
    import rr_pkg::*;
(
    input  wire logic                       mclk_in,
    input  wire logic                       rst_b_in,
    input  wire logic [rr_pkg::INSTR_W-1:0] instr_in,
    input  wire logic                       instr_valid_in,
    input  wire logic [rr_pkg::PC_W-1:0]    stack_top_in,
    input  wire logic [rr_pkg::DATA_W-1:0]  shadow_working_reg_in,
    input  wire logic [rr_pkg::DATA_W-1:0]  shadow_status_reg_in,
    input  wire logic [3:0]                 shadow_bank_select_reg_in,
    input  wire logic [rr_pkg::ADDR_W-1:0]  index_base_in,
    input  wire logic [rr_pkg::DATA_W-1:0]  mem_rdata_in,
    input  wire logic [rr_pkg::RADDR_W-1:0] reg_addr_in,
    input  wire logic [rr_pkg::DATA_W-1:0]  reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [rr_pkg::DATA_W-1:0]  reg_rdata_out,
    output logic      [1:0]                 phase_out,
    output logic                            busy_out,
    output logic      [rr_pkg::PC_W-1:0]    pc_out,
    output logic                            pc_load_out,
    output logic                            stack_pop_out,
    output logic      [rr_pkg::ADDR_W-1:0]  mem_addr_out,
    output logic                            mem_rd_out,
    output logic                            mem_wr_out,
    output logic      [rr_pkg::DATA_W-1:0]  mem_wdata_out,
    output logic      [rr_pkg::DATA_W-1:0]  working_reg_out,
    output logic      [rr_pkg::DATA_W-1:0]  status_reg_out,
    output logic      [3:0]                 bank_select_reg_out,
    output logic                            high_prio_global_int_enable_out,
    output logic                            low_prio_global_int_enable_out
);
    import rr_pkg::*;

    function automatic rr_op_t decode_op(input logic [INSTR_W-1:0] w);
        rr_op_t op;
        op = OP_NONE;
        if ((w & MSK_RET_INT) == PAT_RET_INT) begin
            op = OP_RET_INT;
        end else if ((w & MSK_RETURN) == PAT_RETURN) begin
            op = OP_RETURN;
        end else if ((w & MSK_RET_LIT) == PAT_RET_LIT) begin
            op = OP_RET_LIT;
        end else if ((w & MSK_ROT_C) == PAT_ROT_C) begin
            op = OP_ROT_C;
        end else if ((w & MSK_ROT_NC) == PAT_ROT_NC) begin
            op = OP_ROT_NC;
        end
        return op;
    endfunction

    function automatic logic [ADDR_W-1:0] resolve_addr(
        input logic [7:0]        f,
        input logic              a,
        input logic              ext,
        input logic [3:0]        bank,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] addr;
        addr = {bank, f};
        if (!a) begin
            if (ext && (f <= ILO_LIMIT)) begin
                addr = base + {4'h0, f};
            end else if (f >= ACCESS_SPLIT) begin
                addr = {ACCESS_HI_BK, f};
            end else begin
                addr = {ACCESS_LO_BK, f};
            end
        end
        return addr;
    endfunction

    rr_state_t             state_reg, state_next;
    rr_op_t                op_reg, op_next;
    logic [INSTR_W-1:0]    instr_reg, instr_next;
    logic [1:0]            phase_reg, phase_next;
    logic [1:0]            ctrl_reg, ctrl_next;
    logic [DATA_W-1:0]     work_reg, work_next;
    logic [DATA_W-1:0]     status_reg, status_next;
    logic [3:0]            bank_reg, bank_next;
    logic                  ien_high_reg, ien_high_next;
    logic                  ien_low_reg, ien_low_next;
    logic [PC_W-1:0]       pc_reg, pc_next;
    logic                  pc_load_reg, pc_load_next;
    logic                  pop_reg, pop_next;
    logic [ADDR_W-1:0]     maddr_reg, maddr_next;
    logic                  mrd_reg, mrd_next;
    logic                  mwr_reg, mwr_next;
    logic [DATA_W-1:0]     mwdata_reg, mwdata_next;
    logic [DATA_W-1:0]     rdata_reg, rdata_next;
    logic                  busy_reg, busy_next;
    logic [DATA_W-1:0]     rot_result;
    logic                  rot_carry;
    logic                  rot_neg;
    logic                  rot_zero;
    logic                  is_return;
    logic                  is_rotate;

    rr_rotate_unit u_rotate (
        .src_in        (mem_rdata_in),
        .carry_in      (status_reg[ST_C_BIT]),
        .thru_carry_in (op_reg == OP_ROT_C),
        .result_out    (rot_result),
        .carry_out     (rot_carry),
        .neg_out       (rot_neg),
        .zero_out      (rot_zero)
    );

    assign is_return = (op_reg == OP_RET_INT) || (op_reg == OP_RET_LIT) || (op_reg == OP_RETURN);
    assign is_rotate = (op_reg == OP_ROT_C) || (op_reg == OP_ROT_NC);

    // Sequencing: phase counter, decode and the stall cycle of returns
    always_comb begin
        phase_next = phase_reg + 2'h1;
        state_next = state_reg;
        op_next    = op_reg;
        instr_next = instr_reg;
        busy_next  = busy_reg;
        case (phase_reg)
            PH_Q1: begin
                if ((state_reg == ST_RUN) && instr_valid_in) begin
                    op_next    = decode_op(instr_in);
                    instr_next = instr_in;
                end
            end
            PH_Q3: begin
                // Busy covers the whole following cycle of a return
                busy_next = is_return || (state_reg == ST_STALL);
            end
            PH_Q4: begin
                op_next = OP_NONE;
                case (state_reg)
                    ST_RUN: begin
                        state_next = is_return ? ST_STALL : ST_RUN;
                    end
                    ST_STALL: begin
                        state_next = ST_RUN;
                        busy_next  = 1'b0;
                    end
                    default: begin
                        state_next = ST_RUN;
                    end
                endcase
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            phase_reg <= PH_Q1;
            state_reg <= ST_RUN;
            op_reg    <= OP_NONE;
            instr_reg <= 16'h0000;
            busy_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            state_reg <= state_next;
            op_reg    <= op_next;
            instr_reg <= instr_next;
            busy_reg  <= busy_next;
        end
    end

    // Datapath, core register file and software access
    always_comb begin
        ctrl_next     = ctrl_reg;
        work_next     = work_reg;
        status_next   = status_reg;
        bank_next     = bank_reg;
        ien_high_next = ien_high_reg;
        ien_low_next  = ien_low_reg;
        pc_next       = pc_reg;
        pc_load_next  = 1'b0;
        pop_next      = 1'b0;
        maddr_next    = maddr_reg;
        mrd_next      = 1'b0;
        mwr_next      = 1'b0;
        mwdata_next   = mwdata_reg;
        rdata_next    = RST_BYTE;

        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL:   rdata_next = {6'h00, ctrl_reg};
                REG_WORK:   rdata_next = work_reg;
                REG_STATUS: rdata_next = status_reg;
                REG_BANK:   rdata_next = {4'h0, bank_reg};
                REG_INTEN:  rdata_next = {6'h00, ien_low_reg, ien_high_reg};
                REG_CORE:   rdata_next = {busy_reg, 1'b0, op_reg};
                default:    rdata_next = RST_BYTE;
            endcase
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL:   ctrl_next = reg_wdata_in[1:0];
                REG_WORK:   work_next = reg_wdata_in;
                REG_STATUS: status_next = reg_wdata_in;
                REG_BANK:   bank_next = reg_wdata_in[3:0];
                REG_INTEN: begin
                    ien_high_next = reg_wdata_in[INTEN_HIGH_BIT];
                    ien_low_next  = reg_wdata_in[INTEN_LOW_BIT];
                end
                default: begin
                end
            endcase
        end

        // Core updates follow the bus so a hardware set wins a software clear
        if ((phase_reg == PH_Q1) && (state_reg == ST_RUN) && instr_valid_in) begin
            if ((decode_op(instr_in) == OP_ROT_C) || (decode_op(instr_in) == OP_ROT_NC)) begin
                maddr_next = resolve_addr(instr_in[7:0], instr_in[BIT_ACCESS],
                    ctrl_reg[CTRL_EXT_BIT], bank_reg, index_base_in);
                mrd_next   = 1'b1;
            end
        end
        if ((phase_reg == PH_Q3) && is_rotate) begin
            if (instr_reg[BIT_DEST]) begin
                mwr_next    = 1'b1;
                mwdata_next = rot_result;
            end else begin
                work_next = rot_result;
            end
            status_next[ST_N_BIT] = rot_neg;
            status_next[ST_Z_BIT] = rot_zero;
            status_next[ST_C_BIT] = rot_carry;
        end
        if ((phase_reg == PH_Q3) && is_return) begin
            // The program counter is reloaded from the stack top; no latch register is driven
            pc_next      = stack_top_in;
            pc_load_next = 1'b1;
            pop_next     = 1'b1;
            if (op_reg == OP_RET_LIT) begin
                work_next = instr_reg[7:0];
            end else if (instr_reg[BIT_SHADOW]) begin
                work_next   = shadow_working_reg_in;
                status_next = shadow_status_reg_in;
                bank_next   = shadow_bank_select_reg_in;
            end
            if (op_reg == OP_RET_INT) begin
                if (ctrl_reg[CTRL_RETLOW_BIT]) begin
                    ien_low_next = 1'b1;
                end else begin
                    ien_high_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            ctrl_reg     <= RST_CTRL;
            work_reg     <= RST_BYTE;
            status_reg   <= RST_BYTE;
            bank_reg     <= RST_BANK;
            ien_high_reg <= 1'b0;
            ien_low_reg  <= 1'b0;
            pc_reg       <= RST_PC;
            pc_load_reg  <= 1'b0;
            pop_reg      <= 1'b0;
            maddr_reg    <= RST_ADDR;
            mrd_reg      <= 1'b0;
            mwr_reg      <= 1'b0;
            mwdata_reg   <= RST_BYTE;
            rdata_reg    <= RST_BYTE;
        end else begin
            ctrl_reg     <= ctrl_next;
            work_reg     <= work_next;
            status_reg   <= status_next;
            bank_reg     <= bank_next;
            ien_high_reg <= ien_high_next;
            ien_low_reg  <= ien_low_next;
            pc_reg       <= pc_next;
            pc_load_reg  <= pc_load_next;
            pop_reg      <= pop_next;
            maddr_reg    <= maddr_next;
            mrd_reg      <= mrd_next;
            mwr_reg      <= mwr_next;
            mwdata_reg   <= mwdata_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata_out                   = rdata_reg;
    assign phase_out                       = phase_reg;
    assign busy_out                        = busy_reg;
    assign pc_out                          = pc_reg;
    assign pc_load_out                     = pc_load_reg;
    assign stack_pop_out                   = pop_reg;
    assign mem_addr_out                    = maddr_reg;
    assign mem_rd_out                      = mrd_reg;
    assign mem_wr_out                      = mwr_reg;
    assign mem_wdata_out                   = mwdata_reg;
    assign working_reg_out                 = work_reg;
    assign status_reg_out                  = status_reg;
    assign bank_select_reg_out             = bank_reg;
    assign high_prio_global_int_enable_out = ien_high_reg;
    assign low_prio_global_int_enable_out  = ien_low_reg;

endmodule // rr_exec_core

`default_nettype wire

// [inc/rr_pkg.sv]
/*
 Package for the return and rotate execution slice: opcode patterns,
 phase codes, register offsets, field positions, reset values and types.
 Assumes it is compiled before every design file that imports it.
*/
package rr_pkg;

    localparam int INSTR_W = 16;
    localparam int PC_W    = 21;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 12;
    localparam int RADDR_W = 3;

    // Opcode patterns and the masks that pick the fixed bits
    localparam logic [15:0] PAT_RET_INT = 16'h0010;
    localparam logic [15:0] MSK_RET_INT = 16'hFFFE;
    localparam logic [15:0] PAT_RETURN  = 16'h0012;
    localparam logic [15:0] MSK_RETURN  = 16'hFFFE;
    localparam logic [15:0] PAT_RET_LIT = 16'h0C00;
    localparam logic [15:0] MSK_RET_LIT = 16'hFF00;
    localparam logic [15:0] PAT_ROT_C   = 16'h3400;
    localparam logic [15:0] MSK_ROT_C   = 16'hFC00;
    localparam logic [15:0] PAT_ROT_NC  = 16'h4400;
    localparam logic [15:0] MSK_ROT_NC  = 16'hFC00;

    // Instruction word fields
    localparam int BIT_SHADOW = 0;
    localparam int BIT_ACCESS = 8;
    localparam int BIT_DEST   = 9;

    // Phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // Addressing constants
    localparam logic [7:0] ILO_LIMIT    = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BK = 4'h0;

    // Status field positions
    localparam int ST_C_BIT = 0;
    localparam int ST_Z_BIT = 2;
    localparam int ST_N_BIT = 4;

    // Control field positions
    localparam int CTRL_EXT_BIT     = 0;
    localparam int CTRL_RETLOW_BIT  = 1;
    localparam int INTEN_HIGH_BIT   = 0;
    localparam int INTEN_LOW_BIT    = 1;

    // Register offsets
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_WORK   = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam logic [2:0] REG_BANK   = 3'h3;
    localparam logic [2:0] REG_INTEN  = 3'h4;
    localparam logic [2:0] REG_CORE   = 3'h5;

    // Reset values
    localparam logic [7:0]    RST_BYTE = 8'h00;
    localparam logic [3:0]    RST_BANK = 4'h0;
    localparam logic [1:0]    RST_CTRL = 2'h0;
    localparam logic [PC_W-1:0] RST_PC = 21'h000000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 12'h000;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_STALL = 2'b10
    } rr_state_t;

    typedef enum logic [5:0] {
        OP_NONE    = 6'b000001,
        OP_RET_INT = 6'b000010,
        OP_RET_LIT = 6'b000100,
        OP_RETURN  = 6'b001000,
        OP_ROT_C   = 6'b010000,
        OP_ROT_NC  = 6'b100000
    } rr_op_t;

endpackage

// [verilog/rr_rotate_unit.sv]
/*
 Rotate-left datapath: rotates one byte with or without the carry and
 derives the carry, negative and zero results.
 Assumes a purely combinational use by the execution core.
*/
`timescale 1ns/1ps
`default_nettype none

module rr_rotate_unit
    import rr_pkg::*;
(
    input  wire logic [rr_pkg::DATA_W-1:0] src_in,
    input  wire logic                      carry_in,
    input  wire logic                      thru_carry_in,
    output logic      [rr_pkg::DATA_W-1:0] result_out,
    output logic                           carry_out,
    output logic                           neg_out,
    output logic                           zero_out
);

    always_comb begin
        result_out = {src_in[DATA_W-2:0], src_in[DATA_W-1]};
        if (thru_carry_in) begin
            result_out[0] = carry_in;
        end
        carry_out  = thru_carry_in ? src_in[DATA_W-1] : carry_in;
        neg_out    = result_out[DATA_W-1];
        zero_out   = (result_out == RST_BYTE);
    end

endmodule // rr_rotate_unit

`default_nettype wire

// [test/rr_exec_monitor.sv]
/*
 Checker for the return and rotate execution core: pop and load pairing,
 stall length, rotate phases and what may change the live registers.
 Assumes it is bound to rr_exec_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module rr_exec_monitor
    import rr_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic [15:0] instr_in,
    input wire logic        instr_valid_in,
    input wire logic [20:0] stack_top_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [1:0]  phase_out,
    input wire logic        busy_out,
    input wire logic [20:0] pc_out,
    input wire logic        pc_load_out,
    input wire logic        stack_pop_out,
    input wire logic [11:0] mem_addr_out,
    input wire logic        mem_rd_out,
    input wire logic        mem_wr_out,
    input wire logic [7:0]  working_reg_out,
    input wire logic [7:0]  status_reg_out,
    input wire logic [3:0]  bank_select_reg_out,
    input wire logic        high_prio_global_int_enable_out,
    input wire logic        low_prio_global_int_enable_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // Second instruction cycle of a return is a stall
    sequence stall_s;
        busy_out[*5] ##1 !busy_out;
    endsequence

    sequence rot_s;
        phase_out == PH_Q2 ##2 phase_out == PH_Q4;
    endsequence

    pop_load_pair_a: assert property (
        (pc_load_out || stack_pop_out) |-> pc_load_out && stack_pop_out && phase_out == PH_Q4)
        else $error("pop and load not paired in Q4");
    pc_source_a: assert property (pc_load_out |-> pc_out == $past(stack_top_in))
        else $error("pc not loaded from stack top");
    stall_span_a: assert property ($rose(busy_out) |-> stall_s)
        else $error("stall length wrong");
    stall_start_a: assert property (pc_load_out |-> $rose(busy_out))
        else $error("stall not started with load");
    read_phase_a: assert property (mem_rd_out |-> rot_s)
        else $error("rotate read not in Q2");
    write_cause_a: assert property (
        mem_wr_out |-> $past(mem_rd_out, 2) && phase_out == PH_Q4)
        else $error("write without read two cycles before");
    addr_hold_a: assert property (
        mem_wr_out |-> mem_addr_out == $past(mem_addr_out, 2))
        else $error("write address differs from read");
    enable_cause_a: assert property (
        ($rose(high_prio_global_int_enable_out) || $rose(low_prio_global_int_enable_out))
        && !$past(reg_wr_in) |-> pc_load_out)
        else $error("enable set outside a return");
    flag_cause_a: assert property (
        $changed(status_reg_out) && !$past(reg_wr_in) |-> phase_out == PH_Q4)
        else $error("status changed outside Q4");
    work_cause_a: assert property (
        $changed(working_reg_out) && !$past(reg_wr_in) |-> phase_out == PH_Q4)
        else $error("working changed outside Q4");
    bank_cause_a: assert property (
        $changed(bank_select_reg_out) && !$past(reg_wr_in) |-> pc_load_out)
        else $error("bank changed outside a return");
endmodule // rr_exec_monitor

bind rr_exec_core rr_exec_monitor mon_u (.mclk_in, .rst_b_in, .instr_in, .instr_valid_in,
    .stack_top_in, .reg_wr_in, .reg_rdata_out, .phase_out, .busy_out, .pc_out, .pc_load_out,
    .stack_pop_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .working_reg_out,
    .status_reg_out, .bank_select_reg_out, .high_prio_global_int_enable_out,
    .low_prio_global_int_enable_out);

`default_nettype wire

// [test/return_and_rotate_exec_tb.sv]
/*
 Self-checking bench for rr_exec_core: rotates in all addressing modes,
 every return kind with and without shadows, register port reads.
 Assumes the checker is bound separately; the bench plays the stack.
*/
`timescale 1ns/1ps
`default_nettype none

module return_and_rotate_exec_tb;
    import rr_pkg::*;

    logic        mclk_in, rst_b_in, instr_valid_in, reg_wr_in, reg_rd_in;
    logic        busy_out, pc_load_out, stack_pop_out, mem_rd_out, mem_wr_out;
    logic        high_prio_global_int_enable_out, low_prio_global_int_enable_out;
    logic [15:0] instr_in;
    logic [20:0] stack_top_in, pc_out;
    logic [7:0]  shadow_working_reg_in, shadow_status_reg_in, mem_rdata_in, reg_wdata_in;
    logic [7:0]  reg_rdata_out, mem_wdata_out, working_reg_out, status_reg_out;
    logic [3:0]  shadow_bank_select_reg_in, bank_select_reg_out;
    logic [11:0] index_base_in, mem_addr_out;
    logic [2:0]  reg_addr_in;
    logic [1:0]  phase_out;
    int          bad_count, checks;

    rr_exec_core dut_u (.mclk_in, .rst_b_in, .instr_in, .instr_valid_in, .stack_top_in,
        .shadow_working_reg_in, .shadow_status_reg_in, .shadow_bank_select_reg_in,
        .index_base_in, .mem_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .phase_out, .busy_out, .pc_out, .pc_load_out, .stack_pop_out,
        .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out, .working_reg_out,
        .status_reg_out, .bank_select_reg_out, .high_prio_global_int_enable_out,
        .low_prio_global_int_enable_out);

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    task automatic summarize();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask

    // Issue in the next Q1; returns in the Q4 cycle of that instruction
    task automatic go(input logic [15:0] i, input logic [7:0] md, input logic [20:0] top);
        int n;
        n = 0;
        #1;
        while (phase_out !== PH_Q4 && n < 8) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk(phase_out, PH_Q4);
        @(posedge mclk_in);
        instr_in <= i;
        instr_valid_in <= 1'b1;
        mem_rdata_in <= md;
        stack_top_in <= top;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        instr_in <= ~i;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    task automatic rot(input logic [15:0] i, input logic [7:0] md, st0, res, st1,
                       input logic [11:0] ad);
        wr(REG_STATUS, st0);
        go(i, md, stack_top_in);
        chk(mem_addr_out, ad);
        chk(mem_wr_out, i[9]);
        if (i[9])
            chk(mem_wdata_out, res);
        else
            chk(working_reg_out, res);
        chk(status_reg_out, st1);
    endtask

    task automatic ret(input logic [15:0] i, input logic [20:0] top, input logic [7:0] w, st,
                       input logic [3:0] bk, input logic hi, lo);
        go(i, 8'h00, top);
        chk(pc_load_out, 1'b1);
        chk(stack_pop_out, 1'b1);
        chk(pc_out, top);
        chk(working_reg_out, w);
        chk(status_reg_out, st);
        chk(bank_select_reg_out, bk);
        chk(high_prio_global_int_enable_out, hi);
        chk(low_prio_global_int_enable_out, lo);
        chk(busy_out, 1'b1);
        // A rotate offered in the stall cycle must be ignored
        instr_in <= 16'h3400;
        instr_valid_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
        chk(mem_rd_out, 1'b0);
        repeat (2) @(posedge mclk_in);
        #1;
        chk(busy_out, 1'b1);
        instr_valid_in <= 1'b0;
        stack_top_in <= ~top;
    endtask

    initial begin
        repeat (5000) @(posedge mclk_in);
        bad_count++;
        summarize();
    end

    initial begin
        bad_count = 0;
        checks = 0;
        rst_b_in = 1'b0;
        {instr_valid_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {instr_in, stack_top_in, mem_rdata_in} = '0;
        shadow_working_reg_in = 8'hA5;
        shadow_status_reg_in = 8'h15;
        shadow_bank_select_reg_in = 4'hC;
        index_base_in = 12'h100;
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd(REG_CTRL, 8'h00);
        rd(REG_INTEN, 8'h00);
        rd(REG_CORE, 8'h01);
        wr(REG_BANK, 8'h05);
        rot(16'h3734, 8'hE6, 8'h01, 8'hCD, 8'h11, 12'h534);
        rot(16'h3480, 8'h80, 8'h00, 8'h00, 8'h05, 12'hF80);
        rot(16'h4612, 8'h81, 8'h01, 8'h03, 8'h01, 12'h012);
        wr(REG_CTRL, 8'h01);
        rot(16'h445F, 8'h40, 8'h00, 8'h80, 8'h10, 12'h15F);
        rot(16'h3660, 8'h7F, 8'h00, 8'hFE, 8'h10, 12'hF60);
        rot(16'h4700, 8'h00, 8'h01, 8'h00, 8'h05, 12'h500);
        ret(16'h0012, 21'h012345, 8'h80, 8'h05, 4'h5, 1'b0, 1'b0);
        ret(16'h0010, 21'h1ABCDE, 8'h80, 8'h05, 4'h5, 1'b1, 1'b0);
        wr(REG_INTEN, 8'h00);
        wr(REG_CTRL, 8'h03);
        ret(16'h0011, 21'h00F0F0, 8'hA5, 8'h15, 4'hC, 1'b0, 1'b1);
        ret(16'h0C3C, 21'h123456, 8'h3C, 8'h15, 4'hC, 1'b0, 1'b1);
        shadow_working_reg_in <= 8'h5A;
        shadow_status_reg_in <= 8'h0A;
        shadow_bank_select_reg_in <= 4'h3;
        ret(16'h0013, 21'h055555, 8'h5A, 8'h0A, 4'h3, 1'b0, 1'b1);
        shadow_working_reg_in <= 8'hA5;
        shadow_status_reg_in <= 8'h15;
        shadow_bank_select_reg_in <= 4'hC;
        ret(16'h0CFF, 21'h0AAAAA, 8'hFF, 8'h0A, 4'h3, 1'b0, 1'b1);
        rd(REG_WORK, 8'hFF);
        rd(REG_INTEN, 8'h02);
        rd(3'h7, 8'h00);
        rd(REG_CTRL, 8'h03);
        summarize();
    end
endmodule // return_and_rotate_exec_tb

`default_nettype wire
